// >>> verilog/ssar_pkg.sv
package ssar_pkg;

    // Result word and analog input encoding.
    localparam int CODE_W = 16;
    localparam int IN_W = 18;
    localparam logic signed [IN_W-1:0] CODE_MAX = 18'sh07fff;
    localparam logic signed [IN_W-1:0] CODE_MIN = -18'sh08000;

    // Falling serial clock edge numbers within a frame.
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] EDGE_DRIVE = 5'h02;
    localparam logic [CNT_W-1:0] EDGE_MSB = 5'h03;
    localparam logic [CNT_W-1:0] EDGE_DONE = 5'h12;

    // Values after reset.
    localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
    localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;

    typedef struct packed {
        logic [CNT_W-1:0] falls;
        logic drive;
        logic dout;
        logic done;
    } ssar_link_t;

    typedef struct packed {
        logic cs_meta;
        logic cs_sync;
        logic cs_last;
        logic done_meta;
        logic done_sync;
        logic [CODE_W-1:0] held;
    } ssar_core_t;

endpackage

// >>> verilog/ssar_readout.sv
`timescale 1ns/1ps
module ssar_readout
(
    input wire logic i_clock, // System clock, 100 MHz.
    input wire logic i_reset, // Asynchronous reset, active high.
    input wire logic i_sclk, // Serial clock from the host.
    input wire logic i_cs_n, // Chip select, active low, from the host.
    input wire logic signed [17:0] i_in_pos, // Positive input, in code steps.
    input wire logic signed [17:0] i_in_neg, // Negative input, in code steps.
    output logic o_dout, // Serial data out.
    output logic o_dout_oe_n, // Data out enable, low while driving.
    output logic o_zero_power_track_state, // Tracking, low power.
    output logic o_input_hold, // Input disconnected, sample held.
    output logic [15:0] o_sample_code // Code held for the current frame.
);

    // ********************************************************************
    // Input conversion
    // ********************************************************************

    // Inputs are expressed in code steps, so one step is twice the
    // reference over the full code range by construction.
    logic signed [ssar_pkg::IN_W:0] diff;
    logic [ssar_pkg::CODE_W-1:0] code_now;

    always_comb
    begin
        diff = i_in_pos - i_in_neg;
        if (diff >= ssar_pkg::CODE_MAX)
        begin
            code_now = ssar_pkg::CODE_MAX[ssar_pkg::CODE_W-1:0];
        end
        else if (diff <= ssar_pkg::CODE_MIN)
        begin
            code_now = ssar_pkg::CODE_MIN[ssar_pkg::CODE_W-1:0];
        end
        else
        begin
            code_now = diff[ssar_pkg::CODE_W-1:0];
        end
    end

    // ********************************************************************
    // System clock side
    // ********************************************************************

    ssar_pkg::ssar_core_t core_reg;
    ssar_pkg::ssar_core_t core_next;
    ssar_pkg::ssar_link_t link_reg;
    ssar_pkg::ssar_link_t link_next;
    logic tracking;

    // The end-of-conversion level comes from the link domain and the chip
    // select from a pin; both pass two flip-flops before the system clock side reads them.
    assign tracking = core_reg.cs_sync | core_reg.done_sync;

    always_comb
    begin
        core_next = core_reg;
        core_next.cs_meta = i_cs_n;
        core_next.cs_sync = core_reg.cs_meta;
        core_next.cs_last = core_reg.cs_sync;
        core_next.done_meta = link_reg.done;
        core_next.done_sync = core_reg.done_meta;
        // The held word follows the input only while tracking, and freezes
        // on the first cycle the chip select is seen low. It is settled a
        // few system cycles after the fall, well before the link reads it
        // on the third serial falling edge, so the word is stable there.
        if (core_reg.cs_sync && tracking)
        begin
            core_next.held = code_now;
        end
    end

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            core_reg <= '{cs_meta: 1'b1, cs_sync: 1'b1, cs_last: 1'b1,
                          done_meta: 1'b0, done_sync: 1'b0,
                          held: ssar_pkg::CODE_RESET};
        end
        else
        begin
            core_reg <= core_next;
        end
    end

    assign o_zero_power_track_state = tracking;
    assign o_input_hold = ~tracking;
    assign o_sample_code = core_reg.held;

    // ********************************************************************
    // Serial link side
    // ********************************************************************

    // Catches whether the clock was low when chip select fell; that fall
    // then stands in for the first falling edge.
    logic early_reg;
    logic [ssar_pkg::CNT_W-1:0] edge_now;
    logic [ssar_pkg::CNT_W-1:0] bit_idx;

    always_ff @(negedge i_cs_n)
    begin
        early_reg <= ~i_sclk;
    end

    always_comb
    begin
        link_next = link_reg;
        edge_now = link_reg.falls + {{(ssar_pkg::CNT_W-1){1'b0}}, early_reg};
        bit_idx = ssar_pkg::EDGE_DONE - edge_now - 5'h01;
        if (edge_now < ssar_pkg::EDGE_DONE)
        begin
            link_next.falls = link_reg.falls + 5'h01;
        end
        if (edge_now + 5'h01 >= ssar_pkg::EDGE_DRIVE)
        begin
            link_next.drive = 1'b1;
        end
        if (edge_now + 5'h01 >= ssar_pkg::EDGE_MSB &&
            edge_now < ssar_pkg::EDGE_DONE)
        begin
            link_next.dout = core_reg.held[bit_idx[3:0]];
        end
        else
        begin
            link_next.dout = 1'b0;
        end
        if (edge_now + 5'h01 >= ssar_pkg::EDGE_DONE)
        begin
            link_next.done = 1'b1;
        end
    end

    // Chip select high clears the link state, which abandons a short
    // cycled conversion and returns the output to high impedance. The
    // serial clock may stop outside frames, so nothing here needs it then.
    // The system reset clears it as well, so the link never starts from an
    // unknown count when chip select has not yet risen since power-up.
    always_ff @(negedge i_sclk or posedge i_cs_n or posedge i_reset)
    begin
        if (i_cs_n || i_reset)
        begin
            link_reg <= '{falls: ssar_pkg::CNT_RESET, drive: 1'b0,
                          dout: 1'b0, done: 1'b0};
        end
        else
        begin
            link_reg <= link_next;
        end
    end

    assign o_dout = link_reg.dout;
    assign o_dout_oe_n = ~link_reg.drive;

endmodule // ssar_readout

// >>> verification/ssar_readout_chk.sv
`timescale 1ns/1ps
module ssar_readout_chk (
    input wire logic i_clock, // Clock.
    input wire logic i_reset, // Reset.
    input wire logic i_sclk, // Serial clock.
    input wire logic i_cs_n, // Select.
    input wire logic signed [17:0] i_in_pos, // Plus.
    input wire logic signed [17:0] i_in_neg, // Minus.
    input wire logic o_dout, // Data.
    input wire logic o_dout_oe_n, // Enable.
    input wire logic o_zero_power_track_state, // Tracking.
    input wire logic o_input_hold, // Held.
    input wire logic [15:0] o_sample_code // Code.
);
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (i_reset);
    logic signed [17:0] diff;
    assign diff = i_in_pos - i_in_neg;
    property p_hold; o_input_hold != o_zero_power_track_state; endproperty
    a_hold: assert property (p_hold) else $error("hold bad");
    property p_active; !o_zero_power_track_state |-> !$past(i_cs_n, 2);
    endproperty
    a_active: assert property (p_active) else $error("no track");
    property p_off; i_cs_n |-> o_dout_oe_n; endproperty
    a_off: assert property (p_off) else $error("dout driven");
    property p_wake; $fell(i_cs_n) ##1 !i_cs_n [*3] |->
        !o_zero_power_track_state; endproperty
    a_wake: assert property (p_wake) else $error("slow wake");
    property p_freeze; $fell(o_zero_power_track_state) |-> ##1 o_sample_code
        == ((diff > 18'sh07fff) ? 16'h7fff : (diff < -18'sh08000) ? 16'h8000
        : diff[15:0]); endproperty
    a_freeze: assert property (p_freeze) else $error("bad code");
    // Three cycles allow the held word to load on the same edge that tracking ends.
    property p_stable; !o_zero_power_track_state [*3] |->
        $stable(o_sample_code); endproperty
    a_stable: assert property (p_stable) else $error("code moved");
    property p_dout; $changed(o_dout) |-> !i_sclk || i_cs_n; endproperty
    a_dout: assert property (p_dout) else $error("dout edge");
    property p_drive; $fell(o_dout_oe_n) |-> !i_cs_n && !o_dout; endproperty
    a_drive: assert property (p_drive) else $error("bad enable");
endmodule // ssar_readout_chk
bind ssar_readout ssar_readout_chk chk (.*);

// >>> verification/ssar_host.sv
`timescale 1ns/1ps
module ssar_host (
    output logic o_sclk, // Serial clock.
    output logic o_cs_n, // Select.
    input wire logic i_line // Data line.
);
    logic [15:0] word = 16'h0000;
    initial o_sclk = 1'b1;
    initial o_cs_n = 1'b1;
    task automatic frame(input int n, input bit early);
        int k;
        word = 16'h0000;
        o_sclk = !early;
        #8 o_cs_n = 1'b0;
        #8 o_sclk = 1'b1;
        #16;
        for (k = early ? 2 : 1; k <= n; k++)
        begin
            o_sclk = 1'b0;
            #16 o_sclk = 1'b1;
            if (k > 2 && k < 19)
                word = {word[14:0], i_line};
            #16;
        end
    endtask
    task automatic close();
        o_cs_n = 1'b1;
        #40;
    endtask
endmodule // ssar_host

// >>> verification/ssar_readout_tb_top.sv
`timescale 1ns/1ps
module ssar_readout_tb_top;
    logic i_clock = 1'b0;
    logic i_reset = 1'b0;
    logic signed [17:0] pos = 18'sh00000;
    logic signed [17:0] neg = 18'sh00000;
    logic sclk, cs_n, dout, oe_n, track;
    logic [15:0] code;
    wire line = oe_n ? 1'bz : dout;
    int errors = 0;
    int tests_run = 0;
    int seed = 25673;
    int pv[4] = '{32767, 40000, -32768, -40000};
    always #5 i_clock = ~i_clock;
    ssar_readout dut (.i_clock(i_clock), .i_reset(i_reset), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_in_pos(pos), .i_in_neg(neg), .o_dout(dout),
        .o_dout_oe_n(oe_n), .o_zero_power_track_state(track),
        .o_input_hold(), .o_sample_code(code));
    ssar_host host (.o_sclk(sclk), .o_cs_n(cs_n), .i_line(line));
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #100000 errors++;
        summarize();
    end
    initial
    begin
        int d;
        int n;
        #1 i_reset = 1'b1;
        repeat (4) @(posedge i_clock);
        @(negedge i_clock) i_reset = 1'b0;
        repeat (3) @(negedge i_clock);
        // Short frames of 10, 13 and 16 edges show a partial word.
        for (int i = 0; i < 12; i++)
        begin
            @(negedge i_clock);
            pos = 18'((i > 3) ? $random(seed) % 40000 : pv[i % 4]);
            neg = 18'((i > 3) ? $random(seed) % 40000 : (i % 2) * -pv[i % 4]);
            d = pos - neg;
            d = d > 32767 ? 32767 : (d < -32768 ? -32768 : d);
            n = (i % 3 == 2) ? 8 + i : 18 + 3 * (i % 3);
            host.frame(n, i[0]);
            if (n != 18)
                check("track", 16'(n > 18), 16'(track));
            check("word", 16'(d) >> (16 - (n < 18 ? n - 2 : 16)), host.word);
            check("code", 16'(d), code);
            host.close();
            if (i == 5)
            begin
                @(negedge i_clock) i_reset = 1'b1;
                @(negedge i_clock) check("reset code", 16'h0000, code);
                check("reset track", 16'h0001, 16'(track));
                @(negedge i_clock) i_reset = 1'b0;
                repeat (3) @(negedge i_clock);
            end
            $display("frame %0d of %0d edges done", i, n);
        end
        summarize();
    end
endmodule // ssar_readout_tb_top
